/* File: common/rcg_pkg.sv */
/*
 Constants, field layout and types of the reference clock generator.
 Assumes a single-clock register port and one control register word.
*/
package rcg_pkg;
   localparam int DIV_W = 15;
   localparam int SEL_W = 4;
   localparam int ADDR_W = 4;
   localparam int SRC_N = 16;

   // Register offset of the control word
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;

   // Field positions
   localparam int DIV_LSB = 16;
   localparam int ON_BIT = 15;
   localparam int STOP_IN_IDLE_BIT = 13;
   localparam int OE_BIT = 12;
   localparam int RUN_IN_SLEEP_BIT = 11;
   localparam int SWEN_BIT = 9;
   localparam int ACT_BIT = 8;
   localparam int SEL_LSB = 0;

   // Sources that ignore the run-in-sleep control
   localparam logic [SEL_W-1:0] SEL_NOSLP0 = 4'h0;
   localparam logic [SEL_W-1:0] SEL_NOSLP1 = 4'h1;

   localparam logic [DIV_W-1:0] DIV_RESET = 15'h0000;
   localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic on;
      logic stop_in_idle;
      logic oe;
      logic run_in_sleep;
      logic [SEL_W-1:0] sel;
   } rcg_ctrl_type;

   localparam rcg_ctrl_type CTRL_RESET = '{DIV_RESET, 1'b0, 1'b0, 1'b0, 1'b0, SEL_RESET};

   typedef enum logic [0:0] {
      RCG_SW_IDLE = 1'b0,
      RCG_SW_WAIT = 1'b1
   } rcg_sw_type;
endpackage

/* File: dv/rcg_monitor.sv */
/* Port checker for rcg_top, bound after the module.
 Assumes writes to offset 0 land in the control word the same cycle. */
`timescale 1ns/1ps
module rcg_monitor (
   // Clock, reset and register port
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [rcg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // Power state and outputs
   input wire logic i_idle,
   input wire logic i_sleep,
   input wire logic o_ref_clock_out_pin,
   input wire logic o_active
);
   logic [31:0] shadow_reg;
   wire sleep_stop = i_sleep && (!shadow_reg[11] || shadow_reg[3:0] <= 4'h1);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) shadow_reg <= 32'h0;
      else if (i_wr && i_addr == rcg_pkg::CTRL_OFFSET) shadow_reg <= i_wdata;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   rsv_bits_a: assert property ({o_rdata[31], o_rdata[14], o_rdata[10], o_rdata[7:4]} == 7'h00)
      else $error("reserved bit read as one");
   rst_clear_a: assert property (disable iff (1'b0) !i_rst_n |=> o_rdata == 32'h0 && !o_active)
      else $error("outputs not cleared by reset");
   rd_stand_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside its cycle");
   pin_off_a: assert property ((!shadow_reg[12])[*3] |-> !o_ref_clock_out_pin)
      else $error("pin driven with pin enable off");
   mod_off_a: assert property ((!shadow_reg[15])[*3] |-> !o_active)
      else $error("active while disabled");
   mod_run_a: assert property ((shadow_reg[15] && !i_idle && !i_sleep)[*3] |-> o_active)
      else $error("not active while enabled");
   idle_halt_a: assert property ((shadow_reg[13] && i_idle)[*3] |-> !o_active)
      else $error("running in idle");
   sleep_halt_a: assert property (sleep_stop [*3] |-> !o_active)
      else $error("running in sleep");
   cover property (shadow_reg[13] && i_idle && shadow_reg[15]);
   cover property (i_sleep && o_active);
   cover property ($rose(o_ref_clock_out_pin));
endmodule
bind rcg_top rcg_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle), .i_sleep(i_sleep),
   .o_ref_clock_out_pin(o_ref_clock_out_pin), .o_active(o_active));

/* File: dv/rcg_tb_top.sv */
/* Self-checking bench for rcg_top.
 Assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/1ps
module rcg_tb_top;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_idle = 1'b0;
   logic i_sleep = 1'b0;
   logic [15:0] i_src = 16'h0;
   logic [31:0] o_rdata;
   logic o_ref_clock_out_pin;
   logic o_active;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   rcg_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle), .i_sleep(i_sleep), .i_src(i_src),
      .o_ref_clock_out_pin(o_ref_clock_out_pin), .o_active(o_active));
   always #10 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      i_src <= {16{cyc[1]}};
      if (cyc == 3000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] act, input logic [31:0] exp);
      n_checks++;
      if (act !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk(o_rdata, exp);
   endtask
   // Rising edges of the pin over a whole number of output periods
   task automatic rises(input int n, input logic [31:0] exp);
      logic last = o_ref_clock_out_pin;
      int k = 0;
      repeat (n) begin
         @(negedge i_clk);
         if (o_ref_clock_out_pin && !last) k++;
         last = o_ref_clock_out_pin;
      end
      chk(32'(k), exp);
   endtask
   task automatic pwr(input logic idl, input logic slp, input logic exp);
      @(posedge i_clk);
      i_idle <= idl;
      i_sleep <= slp;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk({31'h0, o_active}, {31'h0, exp});
   endtask
   task automatic t_regs();
      rd(4'h0, 32'h0);
      wr(4'h0, 32'hffff_7fff);
      rd(4'h0, 32'h7fff_380f);
      wr(4'h1, 32'h0);
      rd(4'h0, 32'h7fff_380f);
      rd(4'h1, 32'h0);
   endtask
   // Divisor writes are made while idle halts the output, so none lands while active
   task automatic t_div();
      pwr(1'b1, 1'b0, 1'b0);
      wr(4'h0, 32'h0002_b202);
      rd(4'h0, 32'h0002_b002);
      pwr(1'b0, 1'b0, 1'b1);
      rises(64, 4);
      pwr(1'b1, 1'b0, 1'b0);
      wr(4'h0, 32'h0001_b002);
      pwr(1'b0, 1'b0, 1'b1);
      rises(64, 4);
      pwr(1'b1, 1'b0, 1'b0);
      wr(4'h0, 32'h0001_b202);
      pwr(1'b0, 1'b0, 1'b1);
      rises(64, 8);
   endtask
   task automatic t_power();
      pwr(1'b0, 1'b1, 1'b0);
      wr(4'h0, 32'h0001_b802);
      pwr(1'b0, 1'b1, 1'b1);
      pwr(1'b1, 1'b1, 1'b0);
      wr(4'h0, 32'h0001_b801);
      pwr(1'b0, 1'b1, 1'b0);
      pwr(1'b1, 1'b1, 1'b0);
      wr(4'h0, 32'h0001_a800);
      pwr(1'b0, 1'b0, 1'b1);
      rises(64, 0);
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_div();
      t_power();
      print_verdict();
   end
endmodule

/* File: hdl/rcg_top.sv */
/*
 Reference clock generator: control register, source select, divider,
 Idle/Sleep gating and output pin drive.
 Assumes source clocks, idle and sleep levels are synchronous to i_clk and
 slower than half its rate.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module rcg_top #(
   parameter int DIV_W = rcg_pkg::DIV_W,
   parameter int SEL_W = rcg_pkg::SEL_W,
   parameter int SRC_N = rcg_pkg::SRC_N
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Register port
   input wire logic [rcg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Chip power state
   input wire logic i_idle,
   input wire logic i_sleep,
   // Source clocks, sampled as levels
   input wire logic [SRC_N-1:0] i_src,
   // Output pin and status
   output logic o_ref_clock_out_pin,
   output logic o_active
);

   initial begin
      if (DIV_W != rcg_pkg::DIV_W || SEL_W != rcg_pkg::SEL_W || SRC_N != (1 << SEL_W)) begin
         $error("rcg_top: unsupported parameter values");
      end
   end

   // Sleep gating ignores run-in-sleep for the two fixed sources
   function automatic logic rcg_run_in_sleep_ignored(input logic [SEL_W-1:0] sel);
      rcg_run_in_sleep_ignored = (sel == rcg_pkg::SEL_NOSLP0) || (sel == rcg_pkg::SEL_NOSLP1);
   endfunction

   rcg_pkg::rcg_ctrl_type ctrl_reg, ctrl_next;
   rcg_pkg::rcg_sw_type sw_reg, sw_next;
   logic [DIV_W-1:0] div_act_reg, div_act_next;
   logic [DIV_W-1:0] cnt_reg, cnt_next;
   logic src_prev_reg;
   logic gen_reg, gen_next;
   logic pin_reg;
   logic act_reg;
   logic [31:0] rdata_reg;

   // Decode
   wire logic hit = (i_addr == rcg_pkg::CTRL_OFFSET);
   wire logic wr_hit = i_wr && hit;
   wire logic rd_hit = i_rd && hit;
   wire logic wr_swen = wr_hit && i_wdata[rcg_pkg::SWEN_BIT];
   wire logic [DIV_W-1:0] wr_div = i_wdata[rcg_pkg::DIV_LSB +: DIV_W];
   wire logic [SEL_W-1:0] wr_sel = i_wdata[rcg_pkg::SEL_LSB +: SEL_W];

   // Run conditions
   wire logic idle_stop = ctrl_reg.stop_in_idle && i_idle;
   wire logic sleep_stop = i_sleep && (!ctrl_reg.run_in_sleep || rcg_run_in_sleep_ignored(ctrl_reg.sel));
   wire logic run = ctrl_reg.on && !idle_stop && !sleep_stop;

   // Source edge detection on the selected source
   wire logic src_now = i_src[ctrl_reg.sel];
   wire logic src_rise = src_now && !src_prev_reg;
   wire logic bypass = (div_act_reg == '0);
   wire logic cnt_wrap = (cnt_reg + 1'b1) == div_act_reg;

   // Switch may complete when the divided clock is at a phase boundary
   wire logic sw_point = !run || bypass || (src_rise && cnt_wrap);

   // Register writes
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_hit) begin
         ctrl_next.div = wr_div;
         ctrl_next.on = i_wdata[rcg_pkg::ON_BIT];
         ctrl_next.stop_in_idle = i_wdata[rcg_pkg::STOP_IN_IDLE_BIT];
         ctrl_next.oe = i_wdata[rcg_pkg::OE_BIT];
         ctrl_next.run_in_sleep = i_wdata[rcg_pkg::RUN_IN_SLEEP_BIT];
         ctrl_next.sel = wr_sel;
      end
   end

   // Divider switch handshake
   always_comb begin
      sw_next = sw_reg;
      div_act_next = div_act_reg;
      unique case (sw_reg)
         rcg_pkg::RCG_SW_IDLE: begin
            if (wr_swen) begin
               sw_next = rcg_pkg::RCG_SW_WAIT;
            end
         end
         rcg_pkg::RCG_SW_WAIT: begin
            if (sw_point) begin
               div_act_next = ctrl_reg.div;
               // A fresh request in the completing cycle keeps the flag set
               if (!wr_swen) begin
                  sw_next = rcg_pkg::RCG_SW_IDLE;
               end
            end
         end
      endcase
      // Disabled: field writes reach the divider at once
      if (!ctrl_reg.on) begin
         div_act_next = ctrl_reg.div;
      end
   end

   // Divider: one output half-period per divisor source periods
   always_comb begin
      cnt_next = cnt_reg;
      gen_next = gen_reg;
      if (!run) begin
         cnt_next = '0;
         gen_next = 1'b0;
      end else if (bypass) begin
         cnt_next = '0;
         gen_next = src_now;
      end else if (src_rise) begin
         if (cnt_wrap) begin
            cnt_next = '0;
            gen_next = !gen_reg;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   // Read data; unimplemented bits stay zero
   wire logic [31:0] rd_word = {1'b0, ctrl_reg.div, ctrl_reg.on, 1'b0, ctrl_reg.stop_in_idle,
      ctrl_reg.oe, ctrl_reg.run_in_sleep, 1'b0, (sw_reg == rcg_pkg::RCG_SW_WAIT), act_reg,
      4'h0, ctrl_reg.sel};

   wire logic pin_next = ctrl_reg.oe && gen_next;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_reg <= rcg_pkg::CTRL_RESET;
         sw_reg <= rcg_pkg::RCG_SW_IDLE;
         div_act_reg <= rcg_pkg::DIV_RESET;
         cnt_reg <= '0;
         gen_reg <= 1'b0;
         src_prev_reg <= 1'b0;
         pin_reg <= 1'b0;
         act_reg <= 1'b0;
         rdata_reg <= rcg_pkg::RDATA_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
         sw_reg <= sw_next;
         div_act_reg <= div_act_next;
         cnt_reg <= cnt_next;
         gen_reg <= gen_next;
         src_prev_reg <= src_now;
         pin_reg <= pin_next;
         act_reg <= run;
         rdata_reg <= rd_hit ? rd_word : rcg_pkg::RDATA_RESET;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_ref_clock_out_pin = pin_reg;
   assign o_active = act_reg;

endmodule
